// ===== nand_host_pkg.sv
package nand_host_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int STROBE_NS       = 40;
	localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_SETTLE_NS  = 100;
	localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register offsets (byte addresses)
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_COL    = 12'h004;
	localparam logic [11:0] REG_ROW    = 12'h008;
	localparam logic [11:0] REG_UPPER  = 12'h00C;
	localparam logic [11:0] REG_DATA   = 12'h010;
	localparam logic [11:0] REG_STATUS = 12'h014;
	localparam logic [11:0] REG_PINS   = 12'h018;

	// Control register fields
	localparam int CTRL_OP_LSB  = 0;
	localparam int CTRL_INV_BIT = 8;

	// Host status register fields
	localparam int HS_BUSY       = 0;
	localparam int HS_ERR        = 1;
	localparam int HS_DATA_OPEN  = 2;
	localparam int HS_CACHE_BUSY = 3;
	localparam int HS_MOVE_OPEN  = 4;
	localparam int HS_MOVE_VALID = 5;
	localparam int HS_NAND_LSB   = 8;

	// Pin control register
	localparam int         PIN_WPN  = 0;
	localparam int         PIN_LOCK = 1;
	localparam logic [1:0] PINS_RST = 2'h3;

	// Device status byte
	localparam int ST_FAIL  = 0;
	localparam int ST_CACHE_OP_FAILED = 1;
	localparam int ST_ARRAY_READY  = 5;
	localparam int ST_RDY   = 6;
	localparam int ST_WPN   = 7;

	// Command codes
	localparam logic [7:0] CMD_READ      = 8'h00;
	localparam logic [7:0] CMD_READ_MOVE = 8'h35;
	localparam logic [7:0] CMD_PROG      = 8'h80;
	localparam logic [7:0] CMD_COL_IN    = 8'h85;
	localparam logic [7:0] CMD_PROG_CONF = 8'h10;
	localparam logic [7:0] CMD_CACHE_CNF = 8'h15;
	localparam logic [7:0] CMD_ERASE     = 8'h60;
	localparam logic [7:0] CMD_ERASE_CNF = 8'hD0;
	localparam logic [7:0] CMD_STATUS_EN = 8'h78;
	localparam logic [7:0] CMD_RESET     = 8'hFF;
	localparam logic [7:0] CMD_UNLOCK_LO = 8'h23;
	localparam logic [7:0] CMD_UNLOCK_HI = 8'h24;
	localparam logic [7:0] CMD_LOCK      = 8'h2A;
	localparam logic [7:0] CMD_LOCK_TGT  = 8'h2C;

	// Address byte selectors
	localparam logic [7:0] A_COL0 = 8'h00;
	localparam logic [7:0] A_COL1 = 8'h01;
	localparam logic [7:0] A_ROW0 = 8'h02;
	localparam logic [7:0] A_ROW1 = 8'h03;
	localparam logic [7:0] A_ROW2 = 8'h04;
	localparam logic [7:0] A_UP0  = 8'h05;
	localparam logic [7:0] A_UP1  = 8'h06;
	localparam logic [7:0] A_UP2  = 8'h07;
	localparam int         BLK_LSB = 6;

	typedef enum logic [3:0] {
		OP_NONE, OP_PROG_START, OP_MOVE_START, OP_COL_CHANGE, OP_PROG_CONFIRM,
		OP_CACHE_CONFIRM, OP_ERASE, OP_READ_MOVE, OP_RESET, OP_UNLOCK, OP_LOCK,
		OP_LOCK_TIGHT, OP_STATUS, OP_WAIT_ARRAY, OP_DATA_OUT, OP_DATA_IN
	} op_t;

	typedef enum logic [2:0] {K_CMD, K_ADDR, K_DIN, K_DOUT, K_WAIT, K_STAT, K_END} kind_t;

	typedef struct packed {
		kind_t      kind;
		logic [7:0] val;
	} step_t;

	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic [7:0] io;
		logic       io_oe_n;
	} nand_pins_t;

endpackage : nand_host_pkg

// ===== nand_bus_cycle.sv
`timescale 1ns/1ns
module nand_bus_cycle
	import nand_host_pkg::*;
#(
	parameter int STROBE_CYCLES = STROBE_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire kind_t      kind_i,
	input  wire logic [7:0] byte_i,
	input  wire logic [7:0] io_i,
	output nand_pins_t      pins_o,
	output logic            done_o,
	output logic [7:0]      rdata_o
);

	typedef enum logic [1:0] {C_IDLE, C_SETUP, C_LOW, C_HIGH} cyc_state_t;

	cyc_state_t state_q;
	logic [7:0] div_q;
	logic       read_q;
	wire        tick = (div_q == 8'h00);

	// Divider restarts at each cycle so every phase is a full strobe time
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q <= 8'h00;
		end else if ((state_q == C_IDLE) || tick) begin
			div_q <= 8'(STROBE_CYCLES - 1);
		end else begin
			div_q <= div_q - 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= C_IDLE;
			pins_o  <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io: 8'h00, io_oe_n: 1'b1};
			done_o  <= 1'b0;
			rdata_o <= 8'h00;
			read_q  <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_q)
				C_IDLE: begin
					if (start_i) begin
						pins_o.ce_n    <= 1'b0;
						pins_o.cle     <= (kind_i == K_CMD);
						pins_o.ale     <= (kind_i == K_ADDR);
						pins_o.io      <= byte_i;
						pins_o.io_oe_n <= (kind_i == K_DOUT);
						read_q         <= (kind_i == K_DOUT);
						state_q        <= C_SETUP;
					end
				end
				C_SETUP: begin
					if (tick) begin
						pins_o.we_n <= read_q;
						pins_o.re_n <= ~read_q;
						state_q     <= C_LOW;
					end
				end
				C_LOW: begin
					if (tick) begin
						// Sample before RE# rises, while the device still drives
						if (read_q) begin
							rdata_o <= io_i;
						end
						pins_o.we_n <= 1'b1;
						pins_o.re_n <= 1'b1;
						state_q     <= C_HIGH;
					end
				end
				default: begin
					if (tick) begin
						pins_o.cle     <= 1'b0;
						pins_o.ale     <= 1'b0;
						pins_o.io_oe_n <= 1'b1;
						done_o         <= 1'b1;
						state_q        <= C_IDLE;
					end
				end
			endcase
		end
	end

endmodule : nand_bus_cycle

// ===== nand_host_ctrl.sv
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
// Summary of operation
// RULE_01: Cached program sends 80h, column and row address, data, then 15h.
// RULE_02: Device clears its cache register on 80h; host treats moved data as lost.
// RULE_03: Program start is allowed when idle or while a cached program runs.
// RULE_04: After 15h the device is busy; host waits on ready/busy before continuing.
// RULE_05: Column change 85h may be sent any time during data input.
// RULE_06: During cached program, host reads status to see the previous cache result.
// RULE_07: Wait-array operation polls status until array ready, then keeps both fail bits.
// RULE_08: Busy periods are tracked on ready/busy and by status reads.
// RULE_09: Host only uses the enhanced 78h status read with die address.
// RULE_10: Erase is 60h, three row cycles, D0h; issued only when fully ready.
// RULE_11: After erase or program completes, host reads status and keeps the fail bit.
// RULE_12: Read-for-move is a page read ending with 35h instead of 30h.
// RULE_13: Between move read and move program only status and column commands go out; host also lets reset (FFh) go out then.
// RULE_14: Reset after a move read invalidates the cache for later moves.
// RULE_15: No other die operations run while a move is open; host still accepts reset while a move is open.
// RULE_16: Program-for-move uses 85h then 10h, keeping cache contents.
// RULE_17: Lock pin level at power-on selects whether block lock commands work.
// RULE_18: Device refuses lock changes once locked tight.
// RULE_19: Write protect low locks all non-tight blocks until a new unlock.
// RULE_20: Unlock is 23h lower bound, 24h upper bound, invert flag in page bit 0.
// RULE_21: Unlock lower block must be below upper; other page bits sent as zero.
// RULE_22: A new unlock replaces the previous unlocked range.
// RULE_23: Program or erase to a locked block fails with status bit 7 low.
// RULE_24: 2Ah relocks all blocks, 2Ch enters lock tight.
// RULE_25: Device ignores commands not valid for its current ready state.
module nand_host_ctrl
	import nand_host_pkg::*;
#(
	parameter int STROBE_CYCLES = STROBE_CYC,
	parameter int SETTLE_CYCLES = BUSY_SETTLE_CYC
) (
	input  wire logic        MCLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic             CE_N_O,
	output logic             CLE_O,
	output logic             ALE_O,
	output logic             WE_N_O,
	output logic             RE_N_O,
	output logic      [7:0]  IO_O,
	output logic             IO_OE_N_O,
	input  wire logic [7:0]  IO_I,
	input  wire logic        RB_N_I,
	output logic             WP_N_O,
	output logic             LOCK_O
);

	typedef enum logic [2:0] {E_IDLE, E_STEP, E_CYC, E_SETTLE, E_RB} eng_state_t;

	function automatic step_t st(kind_t k, logic [7:0] v);
		step_t s;
		s.kind = k;
		s.val  = v;
		return s;
	endfunction : st

	// Micro-sequence of every host operation
	function automatic step_t step_of(op_t op, logic [3:0] n);
		step_t seq [16];
		seq = '{default: st(K_END, 8'h00)};
		case (op)
			OP_PROG_START: seq = '{0: st(K_CMD, CMD_PROG), 1: st(K_ADDR, A_COL0), 2: st(K_ADDR, A_COL1), // RULE_01
				3: st(K_ADDR, A_ROW0), 4: st(K_ADDR, A_ROW1), 5: st(K_ADDR, A_ROW2), default: st(K_END, 8'h00)};
			OP_MOVE_START: seq = '{0: st(K_CMD, CMD_COL_IN), 1: st(K_ADDR, A_COL0), 2: st(K_ADDR, A_COL1), // RULE_16
				3: st(K_ADDR, A_ROW0), 4: st(K_ADDR, A_ROW1), 5: st(K_ADDR, A_ROW2), default: st(K_END, 8'h00)};
			OP_COL_CHANGE: seq = '{0: st(K_CMD, CMD_COL_IN), 1: st(K_ADDR, A_COL0), 2: st(K_ADDR, A_COL1), // RULE_05
				default: st(K_END, 8'h00)};
			OP_PROG_CONFIRM: seq = '{0: st(K_CMD, CMD_PROG_CONF), 1: st(K_WAIT, 8'h00), // RULE_11
				2: st(K_STAT, 8'h00), default: st(K_END, 8'h00)};
			OP_CACHE_CONFIRM: seq = '{0: st(K_CMD, CMD_CACHE_CNF), 1: st(K_WAIT, 8'h00), // RULE_04 RULE_06
				2: st(K_STAT, 8'h00), default: st(K_END, 8'h00)};
			OP_ERASE: seq = '{0: st(K_CMD, CMD_ERASE), 1: st(K_ADDR, A_ROW0), 2: st(K_ADDR, A_ROW1), // RULE_10
				3: st(K_ADDR, A_ROW2), 4: st(K_CMD, CMD_ERASE_CNF), 5: st(K_WAIT, 8'h00),
				6: st(K_STAT, 8'h00), default: st(K_END, 8'h00)};
			OP_READ_MOVE: seq = '{0: st(K_CMD, CMD_READ), 1: st(K_ADDR, A_COL0), 2: st(K_ADDR, A_COL1), // RULE_12
				3: st(K_ADDR, A_ROW0), 4: st(K_ADDR, A_ROW1), 5: st(K_ADDR, A_ROW2),
				6: st(K_CMD, CMD_READ_MOVE), 7: st(K_WAIT, 8'h00), default: st(K_END, 8'h00)};
			OP_RESET: seq = '{0: st(K_CMD, CMD_RESET), 1: st(K_WAIT, 8'h00), default: st(K_END, 8'h00)};
			OP_UNLOCK: seq = '{0: st(K_CMD, CMD_UNLOCK_LO), 1: st(K_ADDR, A_ROW0), 2: st(K_ADDR, A_ROW1), // RULE_20
				3: st(K_ADDR, A_ROW2), 4: st(K_CMD, CMD_UNLOCK_HI), 5: st(K_ADDR, A_UP0),
				6: st(K_ADDR, A_UP1), 7: st(K_ADDR, A_UP2), default: st(K_END, 8'h00)};
			OP_LOCK: seq = '{0: st(K_CMD, CMD_LOCK), default: st(K_END, 8'h00)}; // RULE_24
			OP_LOCK_TIGHT: seq = '{0: st(K_CMD, CMD_LOCK_TGT), default: st(K_END, 8'h00)}; // RULE_24
			OP_STATUS: seq = '{0: st(K_CMD, CMD_STATUS_EN), 1: st(K_ADDR, A_ROW0), 2: st(K_ADDR, A_ROW1), // RULE_09
				3: st(K_ADDR, A_ROW2), 4: st(K_DOUT, 8'h00), default: st(K_END, 8'h00)};
			OP_WAIT_ARRAY: seq = '{0: st(K_STAT, 8'h00), default: st(K_END, 8'h00)}; // RULE_07
			OP_DATA_OUT: seq = '{0: st(K_DOUT, 8'h00), default: st(K_END, 8'h00)};
			OP_DATA_IN: seq = '{0: st(K_DIN, 8'h00), default: st(K_END, 8'h00)};
			default: seq = '{default: st(K_END, 8'h00)};
		endcase
		return seq[n];
	endfunction : step_of

	// APB slave with one wait state
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	wire         setup_acc  = PSEL_I & PENABLE_I & ~pready_q;
	wire         hit_ctrl   = (PADDR_I == REG_CTRL);
	wire         hit_col    = (PADDR_I == REG_COL);
	wire         hit_row    = (PADDR_I == REG_ROW);
	wire         hit_upper  = (PADDR_I == REG_UPPER);
	wire         hit_data   = (PADDR_I == REG_DATA);
	wire         hit_status = (PADDR_I == REG_STATUS);
	wire         hit_pins   = (PADDR_I == REG_PINS);
	wire         hit_any    = hit_ctrl | hit_col | hit_row | hit_upper | hit_data | hit_status | hit_pins;
	wire         wr_en      = PSEL_I & PENABLE_I & pready_q & PWRITE_I & hit_any;

	// Host-side state
	eng_state_t  eng_q;
	op_t         op_q;
	logic [3:0]  step_q;
	logic [7:0]  wait_q;
	logic [15:0] col_q;
	logic [23:0] row_q;
	logic [23:0] upper_q;
	logic        inv_q;
	logic [7:0]  din_q;
	logic [7:0]  rdata_q;
	logic [7:0]  nand_st_q;
	logic        err_q;
	logic        data_open_q;
	logic        cache_busy_q;
	logic        move_open_q;
	logic        move_valid_q;
	logic        wait_array_q;
	logic [1:0]  pins_q;
	logic        cyc_start_q;
	kind_t       cyc_kind_q;
	logic [7:0]  cyc_byte_q;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;
	nand_pins_t  pins;

	wire op_t   new_op   = op_t'(PWDATA_I[CTRL_OP_LSB +: 4]);
	wire        idle     = (eng_q == E_IDLE);
	wire        quiet    = ~data_open_q & ~move_open_q & ~cache_busy_q;
	wire        range_ok = row_q[23:BLK_LSB] < upper_q[23:BLK_LSB];
	wire step_t cur      = step_of(op_q, step_q);
	wire        is_unlk  = (op_q == OP_UNLOCK);
	wire [7:0]  row0     = is_unlk ? {row_q[7:BLK_LSB], 5'h00, inv_q} : row_q[7:0]; // RULE_21
	wire [7:0]  up0      = {upper_q[7:BLK_LSB], 5'h00, inv_q}; // RULE_20
	wire [7:0]  addr_b   = (cur.val == A_COL0) ? col_q[7:0] :
	                       (cur.val == A_COL1) ? col_q[15:8] :
	                       (cur.val == A_ROW0) ? row0 :
	                       (cur.val == A_ROW1) ? row_q[15:8] :
	                       (cur.val == A_ROW2) ? row_q[23:16] :
	                       (cur.val == A_UP0)  ? up0 :
	                       (cur.val == A_UP1)  ? upper_q[15:8] : upper_q[23:16];
	wire [7:0]  cyc_byte = (cur.kind == K_ADDR) ? addr_b : (cur.kind == K_DIN) ? din_q : cur.val;
	wire        end_loop = (op_q == OP_STATUS) & wait_array_q & ~nand_st_q[ST_ARRAY_READY]; // RULE_07

	// Which operations software may start in the current host state
	logic op_ok;
	always_comb begin
		case (new_op)
			OP_PROG_START:    op_ok = ~move_open_q & ~data_open_q; // RULE_03 RULE_15
			OP_MOVE_START:    op_ok = move_valid_q & ~data_open_q; // RULE_14 RULE_16
			OP_COL_CHANGE:    op_ok = data_open_q; // RULE_05
			OP_PROG_CONFIRM:  op_ok = data_open_q;
			OP_CACHE_CONFIRM: op_ok = data_open_q & ~move_open_q;
			OP_ERASE:         op_ok = quiet; // RULE_10 RULE_13
			OP_READ_MOVE:     op_ok = quiet; // RULE_15
			OP_UNLOCK:        op_ok = quiet & range_ok; // RULE_21
			OP_LOCK:          op_ok = quiet;
			OP_LOCK_TIGHT:    op_ok = quiet;
			OP_RESET:         op_ok = 1'b1;
			OP_STATUS:        op_ok = 1'b1; // RULE_08
			OP_WAIT_ARRAY:    op_ok = 1'b1;
			OP_DATA_OUT:      op_ok = 1'b1;
			default:          op_ok = 1'b0;
		endcase
	end

	wire launch_ctrl = wr_en & hit_ctrl & idle & op_ok;
	wire launch_din  = wr_en & hit_data & idle & data_open_q;
	wire refuse      = (wr_en & hit_ctrl & ~(idle & op_ok)) | (wr_en & hit_data & ~(idle & data_open_q));
	wire err_clr     = wr_en & hit_status & PWDATA_I[HS_ERR];

	wire [31:0] status_word = {16'h0000, nand_st_q, 2'b00, move_valid_q, move_open_q,
	                           cache_busy_q, data_open_q, err_q, ~idle};
	wire [31:0] rd_mux = hit_ctrl   ? {23'h000000, inv_q, 4'h0, op_q} :
	                     hit_col    ? {16'h0000, col_q} :
	                     hit_row    ? {8'h00, row_q} :
	                     hit_upper  ? {8'h00, upper_q} :
	                     hit_data   ? {24'h000000, rdata_q} :
	                     hit_status ? status_word :
	                     hit_pins   ? {30'h00000000, pins_q} : 32'h00000000;

	always_ff @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup_acc;
			prdata_q  <= setup_acc ? rd_mux : 32'h00000000;
			pslverr_q <= setup_acc & ~hit_any;
		end
	end

	// Software-owned registers
	always_ff @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			col_q   <= 16'h0000;
			row_q   <= 24'h000000;
			upper_q <= 24'h000000;
			pins_q  <= PINS_RST;
			err_q   <= 1'b0;
		end else begin
			if (wr_en & hit_col)   col_q   <= PWDATA_I[15:0];
			if (wr_en & hit_row)   row_q   <= PWDATA_I[23:0];
			if (wr_en & hit_upper) upper_q <= PWDATA_I[23:0];
			if (wr_en & hit_pins)  pins_q  <= PWDATA_I[1:0]; // RULE_17 RULE_19
			// A refusal in the same cycle as a clear stays visible
			err_q <= refuse | (err_q & ~err_clr);
		end
	end

	// Operation engine
	always_ff @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			eng_q        <= E_IDLE;
			op_q         <= OP_NONE;
			step_q       <= 4'h0;
			wait_q       <= 8'h00;
			inv_q        <= 1'b0;
			din_q        <= 8'h00;
			rdata_q      <= 8'h00;
			nand_st_q    <= 8'h00;
			data_open_q  <= 1'b0;
			cache_busy_q <= 1'b0;
			move_open_q  <= 1'b0;
			move_valid_q <= 1'b0;
			wait_array_q <= 1'b0;
			cyc_start_q  <= 1'b0;
			cyc_kind_q   <= K_CMD;
			cyc_byte_q   <= 8'h00;
		end else begin
			cyc_start_q <= 1'b0;
			case (eng_q)
				E_IDLE: begin
					if (launch_ctrl) begin
						op_q   <= new_op;
						inv_q  <= PWDATA_I[CTRL_INV_BIT];
						step_q <= 4'h0;
						eng_q  <= E_STEP;
						case (new_op)
							OP_PROG_START: begin
								data_open_q  <= 1'b1;
								move_valid_q <= 1'b0; // RULE_02
							end
							OP_MOVE_START:    data_open_q <= 1'b1;
							OP_PROG_CONFIRM: begin
								data_open_q <= 1'b0;
								move_open_q <= 1'b0;
							end
							OP_CACHE_CONFIRM: begin
								data_open_q  <= 1'b0;
								cache_busy_q <= 1'b1; // RULE_04
							end
							OP_READ_MOVE: begin
								move_open_q  <= 1'b1;
								move_valid_q <= 1'b1;
							end
							OP_RESET: begin
								data_open_q  <= 1'b0;
								move_open_q  <= 1'b0;
								move_valid_q <= 1'b0; // RULE_14
								cache_busy_q <= 1'b0;
							end
							OP_WAIT_ARRAY: wait_array_q <= 1'b1;
							default: ;
						endcase
					end else if (launch_din) begin
						op_q   <= OP_DATA_IN;
						din_q  <= PWDATA_I[7:0];
						step_q <= 4'h0;
						eng_q  <= E_STEP;
					end
				end
				E_STEP: begin
					case (cur.kind)
						K_WAIT: begin
							wait_q <= 8'(SETTLE_CYCLES - 1);
							eng_q  <= E_SETTLE;
						end
						K_STAT: begin
							op_q   <= OP_STATUS; // RULE_06 RULE_11
							step_q <= 4'h0;
						end
						K_END: begin
							if (end_loop) begin
								step_q <= 4'h0;
							end else begin
								wait_array_q <= 1'b0;
								eng_q        <= E_IDLE;
							end
						end
						default: begin
							cyc_start_q <= 1'b1;
							cyc_kind_q  <= cur.kind;
							cyc_byte_q  <= cyc_byte;
							eng_q       <= E_CYC;
						end
					endcase
				end
				E_CYC: begin
					if (cyc_done) begin
						if (cur.kind == K_DOUT) begin
							rdata_q <= cyc_rdata;
							if (op_q == OP_STATUS) begin
								nand_st_q <= cyc_rdata; // RULE_23
								if (cyc_rdata[ST_ARRAY_READY]) cache_busy_q <= 1'b0;
							end
						end
						step_q <= step_q + 4'h1;
						eng_q  <= E_STEP;
					end
				end
				E_SETTLE: begin
					// Ready/busy only falls some time after the confirm cycle
					wait_q <= wait_q - 8'h01;
					if (wait_q == 8'h00) eng_q <= E_RB;
				end
				default: begin
					if (RB_N_I) begin // RULE_08
						step_q <= step_q + 4'h1;
						eng_q  <= E_STEP;
					end
				end
			endcase
		end
	end

	nand_bus_cycle #(
		.STROBE_CYCLES(STROBE_CYCLES)
	) u_cycle (
		.clk_i   (MCLK_I),
		.rst_n_i (RESETN_I),
		.start_i (cyc_start_q),
		.kind_i  (cyc_kind_q),
		.byte_i  (cyc_byte_q),
		.io_i    (IO_I),
		.pins_o  (pins),
		.done_o  (cyc_done),
		.rdata_o (cyc_rdata)
	);

	assign PRDATA_O  = prdata_q;
	assign PREADY_O  = pready_q;
	assign PSLVERR_O = pslverr_q;
	assign CE_N_O    = pins.ce_n;
	assign CLE_O     = pins.cle;
	assign ALE_O     = pins.ale;
	assign WE_N_O    = pins.we_n;
	assign RE_N_O    = pins.re_n;
	assign IO_O      = pins.io;
	assign IO_OE_N_O = pins.io_oe_n;
	assign WP_N_O    = pins_q[PIN_WPN];
	assign LOCK_O    = pins_q[PIN_LOCK];

endmodule : nand_host_ctrl

// ===== nand_host_checker.sv
`timescale 1ns/1ns
module nand_host_checker #(
	parameter int STROBE_CYCLES = 2
) (
	input wire logic        MCLK_I,
	input wire logic        RESETN_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        CE_N_O,
	input wire logic        CLE_O,
	input wire logic        ALE_O,
	input wire logic        WE_N_O,
	input wire logic        RE_N_O,
	input wire logic [7:0]  IO_O,
	input wire logic        IO_OE_N_O,
	input wire logic        RB_N_I
);
	logic [3:0] we_cnt_q;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);
	// Counts strobe cycles so the width check needs no long repetition
	always_ff @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			we_cnt_q <= 4'h0;
		end else begin
			we_cnt_q <= WE_N_O ? 4'h0 : we_cnt_q + 4'h1;
		end
	end
	sequence s_access;
		PSEL_I && PENABLE_I && !PREADY_O;
	endsequence
	a_one_wait: assert property ($rose(PENABLE_I) && PSEL_I |-> s_access ##1 PREADY_O)
		else $error("ready not after one wait");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready too long");
	a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	a_we_width: assert property ($rose(WE_N_O) |-> we_cnt_q == STROBE_CYCLES)
		else $error("write strobe width");
	a_drive_write: assert property (!WE_N_O |-> !IO_OE_N_O)
		else $error("bus not driven in write");
	a_latch_stable: assert property (!WE_N_O && !$fell(WE_N_O) |-> $stable(IO_O) && $stable(CLE_O))
		else $error("byte moved in strobe");
	a_no_plain70: assert property (CLE_O && !WE_N_O |-> IO_O != 8'h70)
		else $error("plain status read used");
	a_busy_cmds: assert property (CLE_O && !WE_N_O && !RB_N_I |-> IO_O inside {8'h78, 8'hFF})
		else $error("command while busy");
	a_read_release: assert property (!RE_N_O |-> IO_OE_N_O && WE_N_O && !CE_N_O)
		else $error("bus driven in read");
	a_latch_excl: assert property (!(CLE_O && ALE_O))
		else $error("command and address latch together");
endmodule : nand_host_checker
bind nand_host_ctrl nand_host_checker #(.STROBE_CYCLES(STROBE_CYCLES)) nand_host_checker_inst (
	.MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .CLE_O(CLE_O), .WE_N_O(WE_N_O), .IO_O(IO_O), .IO_OE_N_O(IO_OE_N_O), .RB_N_I(RB_N_I),
	.CE_N_O(CE_N_O), .ALE_O(ALE_O), .RE_N_O(RE_N_O));

// ===== nand_flash_model.sv
`timescale 1ns/1ns
module nand_flash_model (
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic [7:0] io_i,
	input  wire logic       wp_n_i,
	input  wire logic       lock_i,
	output logic      [7:0] io_o,
	output logic            rb_n_o
);
	logic [7:0]  cmd = 8'h00, last = 8'h00;
	logic [23:0] sr = '0;
	logic [11:0] lo = '0, hi = '0, blk;
	logic        array_ready = 1, fail = 0, cache_op_failed = 0, prot = 0, inv = 0, cache_ok = 0, lock_en, all_lk = 1, tight = 0;
	int          acnt = 0;
	assign blk = sr[17:6];
	wire ranged = inv ? (blk < lo || blk > hi) : (blk >= lo && blk <= hi);
	wire locked = lock_en && (all_lk || !ranged);
	// Released bus shows the inverse, not a stale byte
	assign io_o = re_n_i ? ~last : last;
	initial begin
		rb_n_o = 1;
		#15 lock_en = lock_i;
	end
	task automatic busy(input int t1, input int t2);
		rb_n_o = 0;
		array_ready = 0;
		#(t1) rb_n_o = 1;
		#(t2) array_ready = 1;
	endtask : busy
	always @(negedge re_n_i) last = (cmd == 8'h78) ? {!prot, rb_n_o, array_ready, 3'h0, cache_op_failed, fail} : 8'hA5;
	always @(negedge wp_n_i) begin
		all_lk = 1;
		tight = 0;
	end
	always @(posedge we_n_i) begin
		if (ale_i) begin
			// Column bytes skip the row shifter, so a column change keeps the row
			if (acnt >= 2 || !(cmd inside {8'h00, 8'h80, 8'h85})) sr = {io_i, sr[23:8]};
			acnt++;
			if (cmd == 8'h24 && acnt == 3 && !tight) begin
				hi = blk;
				inv = sr[0];
				all_lk = 0;
			end
		end else if (cle_i && (rb_n_o || io_i inside {8'h78, 8'hFF})) begin
			cmd = io_i;
			acnt = 0;
			case (io_i)
				8'h80: cache_ok = 1;
				8'h35: begin
					cache_ok = 1;
					fork busy(400, 0); join_none
				end
				8'hFF: cache_ok = 0;
				8'h24: if (!tight) lo = blk;
				8'h2A: if (!tight) all_lk = 1;
				8'h2C: tight = lock_en;
				8'h10, 8'h15, 8'hD0: begin
					prot = locked;
					if (io_i == 8'h15) cache_op_failed = fail;
					fail = prot || (io_i != 8'hD0 && !cache_ok);
					if (prot) fork busy(200, 0); join_none
					else if (io_i == 8'h15) fork busy(400, 3000); join_none
					else fork busy(3000, 0); join_none
				end
				default: ;
			endcase
		end
	end
endmodule : nand_flash_model

// ===== nand_host_ctrl_bench.sv
`timescale 1ns/1ns
module nand_host_ctrl_bench;
	import nand_host_pkg::*;
	logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, want = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, s = 32'h5;
	logic [7:0]  io_o, dev_io;
	logic        pready, pslverr, ce_n, cle, ale, we_n, re_n, io_oe_n, rb_n, wp_n, lock;
	logic [64:0] q[$];
	logic [64:0] n;
	int          miscompares = 0, n_checks = 0, cyc = 0;
	wire  [7:0]  io_bus = io_oe_n ? dev_io : io_o;
	always #10 mclk = ~mclk;
	nand_host_ctrl nand_host_ctrl_inst (.MCLK_I(mclk), .RESETN_I(resetn), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .CE_N_O(ce_n), .CLE_O(cle), .ALE_O(ale), .WE_N_O(we_n), .RE_N_O(re_n),
		.IO_O(io_o), .IO_OE_N_O(io_oe_n), .IO_I(io_bus), .RB_N_I(rb_n), .WP_N_O(wp_n), .LOCK_O(lock));
	nand_flash_model nand_flash_model_inst (.we_n_i(we_n), .re_n_i(re_n), .cle_i(cle), .ale_i(ale),
		.io_i(io_bus), .wp_n_i(wp_n), .lock_i(lock), .io_o(dev_io), .rb_n_o(rb_n));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		want <= c;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
		want <= 0;
	endtask : apb
	task automatic go(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, 0);
		do apb(0, REG_STATUS, 0, 0); while (rd[HS_BUSY] !== 1'b0);
	endtask : go
	task automatic chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v, input logic e);
		q.push_back({e, m, v});
		apb(0, a, 0, 1);
	endtask : chk
	task automatic cmp(input logic [32:0] g, input logic [32:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR reg %h expected %h seen %h", paddr, e, g);
		end
	endtask : cmp
	task automatic op(input logic [3:0] c, input logic inv);
		go(REG_CTRL, {23'h0, inv, 4'h0, c});
	endtask : op
	task automatic rng(input logic [11:0] l, input logic [11:0] h, input logic inv);
		go(REG_ROW, {14'h0, l, 6'h0});
		go(REG_UPPER, {14'h0, h, 6'h0});
		op(4'h9, inv);
	endtask : rng
	task automatic ers(input logic [11:0] b, input logic ok);
		go(REG_ROW, {14'h0, b, 6'h0});
		op(4'h6, 0);
		chk(REG_STATUS, 32'h8000, {16'h0, ok, 15'h0}, 0);
	endtask : ers
	task automatic dat(input int k);
		repeat (k) begin
			s = xs(s);
			go(REG_DATA, {24'h0, s[7:0]});
		end
	endtask : dat
	// Results are taken at the ready edge, in request order
	always @(posedge mclk) begin
		cyc++;
		if (want && pready === 1'b1) begin
			n = q.pop_front();
			cmp({pslverr, prdata & n[63:32]}, {n[64], n[31:0]});
		end
		if (cyc == 60000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(posedge mclk);
		resetn <= 1;
		chk(REG_PINS, '1, 32'h3, 0);
		chk(12'h0FC, '1, 32'h0, 1);
		rng(2, 5, 0);
		ers(3, 1);
		ers(9, 0);
		rng(6, 8, 1);
		ers(9, 1);
		ers(7, 0);
		go(REG_PINS, 32'h2);
		go(REG_PINS, 32'h3);
		ers(9, 0);
		rng(6, 8, 1);
		op(4'hA, 0);
		ers(9, 0);
		rng(6, 8, 1);
		op(4'hB, 0);
		rng(2, 5, 0);
		ers(7, 0);
		ers(9, 1);
		$display("test lock done");
		go(REG_ROW, 32'h240);
		op(4'h1, 0);
		dat(3);
		go(REG_COL, 32'h10);
		op(4'h3, 0);
		dat(1);
		op(4'h5, 0);
		chk(REG_STATUS, 32'h6008, 32'h4008, 0);
		op(4'h1, 0);
		dat(2);
		op(4'h5, 0);
		op(4'hD, 0);
		chk(REG_STATUS, 32'h2308, 32'h2000, 0);
		$display("test cache done");
		op(4'h7, 0);
		op(4'h2, 0);
		op(4'h4, 0);
		chk(REG_STATUS, 32'h0110, 32'h0, 0);
		op(4'h7, 0);
		op(4'h8, 0);
		op(4'hE, 0);
		chk(REG_DATA, 32'hFF, 32'hA5, 0);
		op(4'hC, 0);
		chk(REG_DATA, 32'hFF, 32'hE0, 0);
		op(4'h2, 0);
		chk(REG_STATUS, 32'h2, 32'h2, 0);
		go(REG_STATUS, 32'h2);
		op(4'h0, 0);
		chk(REG_STATUS, 32'h2, 32'h2, 0);
		$display("test move done");
		test_done();
	end
endmodule : nand_host_ctrl_bench
